// *** design/osc_pkg.sv ***
// constants for the oscillator control and clock select block
// assumes an 8-bit register port from the cpu core, one system clock
package osc_pkg;
  localparam logic [7:0] OSC_CTRL_ADDR   = 8'hfa;
  localparam logic [7:0] OSC_CTRL_RESET  = 8'h00;
  localparam int         PWR_SAVE_BIT    = 7;
  localparam int         MAIN_STOP_BIT   = 3;
  localparam int         SUB_STOP_BIT    = 2;
  localparam int         CLK_SEL_BIT     = 0;
  localparam logic [7:0] OSC_CTRL_MASK   = 8'h8d;
  // oscillator settle time and its cycle count at 50 MHz
  localparam int         SETTLE_NS       = 200;
  localparam int         CLK_PERIOD_NS   = 20;
  localparam int         SETTLE_CYC      = (SETTLE_NS + CLK_PERIOD_NS - 1)
                                           / CLK_PERIOD_NS;
  localparam int         SETTLE_W        = 4;
  localparam logic [SETTLE_W-1:0] SETTLE_LAST =
    SETTLE_W'(SETTLE_CYC - 1);

  typedef enum logic [3:0] {
    SW_MAIN   = 4'b0001,
    SW_TO_SUB = 4'b0010,
    SW_SUB    = 4'b0100,
    SW_TO_MAIN= 4'b1000
  } sw_state_t;
endpackage : osc_pkg

// *** design/osc_ready_if.sv ***
// carries oscillator run requests and ready flags between modules
// assumes both ends share ref_clk
`timescale 1ns/1ns
interface osc_ready_if;
  logic run_req;
  logic ready;
  modport ctrl (output run_req, input ready);
  modport tracker (input run_req, output ready);
endinterface : osc_ready_if

// *** design/osc_settle.sv ***
// waits a settle time after an oscillator is told to run
// assumes run requests come from the clock select control
`timescale 1ns/1ns
module osc_settle
  import osc_pkg::*;
(
  // clock and reset
  input  wire logic   ref_clk,
  input  wire logic   rst,
  // control side
  osc_ready_if.tracker osc
);
  logic [SETTLE_W-1:0] cnt_ff;
  logic                rdy_ff;

  always_ff @(posedge ref_clk) begin
    if (rst || !osc.run_req) begin
      cnt_ff <= '0;
      rdy_ff <= 1'b0;
    end else if (!rdy_ff) begin
      if (cnt_ff == SETTLE_LAST) begin
        rdy_ff <= 1'b1;
      end
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  assign osc.ready = rdy_ff;

  settle_time_a: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(rdy_ff) |-> $past(osc.run_req, SETTLE_CYC))
    else $error("oscillator ready before settle time");
endmodule : osc_settle

// *** design/oscillator_clock_select.sv ***
// oscillator control register and glitch-free system clock select
// assumes cpu register port writes/reads at the register address and
// assumes oscillator clocks are given as enables sampled on ref_clk
`timescale 1ns/1ns

module oscillator_clock_select
  import osc_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // cpu register port
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  output      logic [7:0] reg_rdata,
  // cpu power state
  input  wire logic       stop_mode,
  // oscillator and clock controls
  output      logic       main_osc_en,
  output      logic       sub_osc_en,
  output      logic       sub_pwr_save,
  output      logic       sys_clk_is_sub,
  output      logic       switch_busy
);
  logic [7:0] ctrl_ff;
  logic [7:0] rdata_ff;
  logic       main_en_ff;
  logic       sub_en_ff;
  logic       save_ff;
  logic       sel_ff;
  logic       busy_ff;
  sw_state_t  state_ff;
  logic       wr_hit;
  logic [7:0] wr_val;

  osc_ready_if main_if ();
  osc_ready_if sub_if ();

  osc_settle u_main_settle (
    .ref_clk (ref_clk),
    .rst     (rst),
    .osc     (main_if.tracker)
  );
  osc_settle u_sub_settle (
    .ref_clk (ref_clk),
    .rst     (rst),
    .osc     (sub_if.tracker)
  );

  assign wr_hit = reg_wr && (reg_addr == OSC_CTRL_ADDR);
  assign wr_val = reg_wdata & OSC_CTRL_MASK;

  // register update; hardware clear of bit 7 wins over a write setting it
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_ff <= OSC_CTRL_RESET;
    end else begin
      if (wr_hit) begin
        ctrl_ff <= wr_val;
      end
      if ((wr_hit && wr_val[SUB_STOP_BIT]) ||
          (!wr_hit && ctrl_ff[SUB_STOP_BIT])) begin
        ctrl_ff[PWR_SAVE_BIT] <= 1'b0;
      end
      if (stop_mode && sel_ff) begin
        ctrl_ff[PWR_SAVE_BIT] <= 1'b0;
      end
    end
  end

  // oscillator run requests; keep the active clock running
  assign main_if.run_req = !ctrl_ff[MAIN_STOP_BIT] || !sel_ff
                           || state_ff == SW_TO_MAIN;
  assign sub_if.run_req  = !ctrl_ff[SUB_STOP_BIT] || sel_ff
                           || state_ff == SW_TO_SUB;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_ff <= SW_MAIN;
      sel_ff   <= 1'b0;
    end else begin
      unique case (state_ff)
        SW_MAIN: begin
          if (ctrl_ff[CLK_SEL_BIT]) begin
            state_ff <= SW_TO_SUB;
          end
        end
        SW_TO_SUB: begin
          if (!ctrl_ff[CLK_SEL_BIT]) begin
            state_ff <= SW_MAIN;
          end else if (sub_if.ready) begin
            state_ff <= SW_SUB;
            sel_ff   <= 1'b1;
          end
        end
        SW_SUB: begin
          if (!ctrl_ff[CLK_SEL_BIT]) begin
            state_ff <= SW_TO_MAIN;
          end
        end
        SW_TO_MAIN: begin
          if (ctrl_ff[CLK_SEL_BIT]) begin
            state_ff <= SW_SUB;
          end else if (main_if.ready) begin
            state_ff <= SW_MAIN;
            sel_ff   <= 1'b0;
          end
        end
        default: state_ff <= SW_MAIN;
      endcase
    end
  end

  // registered outputs
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      main_en_ff <= 1'b0;
      sub_en_ff  <= 1'b0;
      save_ff    <= 1'b0;
      busy_ff    <= 1'b0;
      rdata_ff   <= 8'h00;
    end else begin
      main_en_ff <= main_if.run_req;
      sub_en_ff  <= sub_if.run_req;
      save_ff    <= ctrl_ff[PWR_SAVE_BIT];
      busy_ff    <= (state_ff == SW_TO_SUB) || (state_ff == SW_TO_MAIN);
      rdata_ff   <= (reg_addr == OSC_CTRL_ADDR) ? ctrl_ff : 8'h00;
    end
  end

  assign main_osc_en    = main_en_ff;
  assign sub_osc_en     = sub_en_ff;
  assign sub_pwr_save   = save_ff;
  assign sys_clk_is_sub = sel_ff;
  assign switch_busy    = busy_ff;
  assign reg_rdata      = rdata_ff;

  sel_ready_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    $rose(sel_ff) |-> $past(sub_if.ready))
    else $error("switched to sub before it was ready");
  main_ready_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    $fell(sel_ff) |-> $past(main_if.ready))
    else $error("switched to main before it was ready");
  sub_stop_clr_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    ctrl_ff[SUB_STOP_BIT] |-> !ctrl_ff[PWR_SAVE_BIT])
    else $error("save bit set while sub stopped");
  stop_mode_clr_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    stop_mode && sel_ff |=> !ctrl_ff[PWR_SAVE_BIT])
    else $error("save bit kept in stop mode on sub clock");
  // stop mode on main keeps save
  stop_keep_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    stop_mode && !sel_ff && !wr_hit && !ctrl_ff[SUB_STOP_BIT]
    |=> ctrl_ff[PWR_SAVE_BIT] == $past(ctrl_ff[PWR_SAVE_BIT]))
    else $error("save bit changed in stop mode on main clock");
  unused_bits_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    (ctrl_ff & ~OSC_CTRL_MASK) == 8'h00)
    else $error("unused control bit set");
  // main stopped only when not in use
  main_stop_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    ctrl_ff[MAIN_STOP_BIT] && sel_ff && state_ff == SW_SUB
    |=> !main_en_ff)
    else $error("main oscillator not stopped");
  main_run_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    !ctrl_ff[MAIN_STOP_BIT] |=> main_en_ff)
    else $error("main oscillator not running");
  sub_run_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    !ctrl_ff[SUB_STOP_BIT] |=> sub_en_ff)
    else $error("sub oscillator not running");
  // sub stopped only when not in use
  sub_stop_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    ctrl_ff[SUB_STOP_BIT] && !sel_ff && state_ff == SW_MAIN
    |=> !sub_en_ff)
    else $error("sub oscillator not stopped");
  // selection follows a rise of bit 0 held 8 cycles within 20 more cycles
  sel_follow_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    $rose(ctrl_ff[CLK_SEL_BIT]) && !sel_ff
    ##1 ctrl_ff[CLK_SEL_BIT] [*8] |-> ##[0:20] sel_ff)
    else $error("clock select did not follow bit 0");
  save_out_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    ##1 save_ff == $past(ctrl_ff[PWR_SAVE_BIT]))
    else $error("save output does not follow bit 7");

  switch_sub_c: cover property (@(posedge ref_clk) disable iff (rst)
    $rose(sel_ff));
  switch_main_c: cover property (@(posedge ref_clk) disable iff (rst)
    $fell(sel_ff));
  stop_clear_c: cover property (@(posedge ref_clk) disable iff (rst)
    stop_mode && sel_ff && ctrl_ff[PWR_SAVE_BIT]);
  main_off_c: cover property (@(posedge ref_clk) disable iff (rst)
    sel_ff && !main_en_ff);
  save_clr_wr_c: cover property (@(posedge ref_clk) disable iff (rst)
    wr_hit && wr_val[SUB_STOP_BIT] && ctrl_ff[PWR_SAVE_BIT]);
endmodule : oscillator_clock_select

// *** dv/oscillator_clock_select_tb_top.sv ***
// self-checking bench for the oscillator control and clock select block
// assumes the design checks its own assertions; bench drives all ports
`timescale 1ns/1ns
module oscillator_clock_select_tb_top
  import osc_pkg::*;
;
  logic       ref_clk;
  logic       rst;
  logic [7:0] reg_addr;
  logic       reg_wr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic       stop_mode;
  logic       main_osc_en;
  logic       sub_osc_en;
  logic       sub_pwr_save;
  logic       sys_clk_is_sub;
  logic       switch_busy;
  int         n_errors;
  int         num_checks;
  int         cycles;

  oscillator_clock_select oscillator_clock_select_i (
    .ref_clk        (ref_clk),
    .rst            (rst),
    .reg_addr       (reg_addr),
    .reg_wr         (reg_wr),
    .reg_wdata      (reg_wdata),
    .reg_rdata      (reg_rdata),
    .stop_mode      (stop_mode),
    .main_osc_en    (main_osc_en),
    .sub_osc_en     (sub_osc_en),
    .sub_pwr_save   (sub_pwr_save),
    .sys_clk_is_sub (sys_clk_is_sub),
    .switch_busy    (switch_busy)
  );

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic summarize();
    if (n_errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge ref_clk);
    reg_addr  <= addr;
    reg_wdata <= data;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  // read data is registered, so allow two edges after the address
  task automatic rd_chk(input logic [7:0] exp);
    @(posedge ref_clk);
    reg_addr <= OSC_CTRL_ADDR;
    @(posedge ref_clk);
    @(posedge ref_clk);
    #1;
    check(reg_rdata, exp);
  endtask : rd_chk

  // bounded wait for the clock source to reach the wanted side
  task automatic wait_src(input logic exp);
    for (int i = 0; i < 40; i++) begin
      @(posedge ref_clk);
      #1;
      if (sys_clk_is_sub === exp) break;
    end
    check({7'h00, sys_clk_is_sub}, {7'h00, exp});
  endtask : wait_src

  // hang guard: the sequence needs a few hundred cycles at most
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_errors++;
      summarize();
    end
  end

  initial begin
    n_errors   = 0;
    num_checks = 0;
    cycles     = 0;
    rst        = 1'b1;
    reg_addr   = 8'h00;
    reg_wr     = 1'b0;
    reg_wdata  = 8'h00;
    stop_mode  = 1'b0;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    check({6'h00, main_osc_en, sub_osc_en}, 8'h03);
    check({6'h00, switch_busy, sys_clk_is_sub}, 8'h00);
    rd_chk(OSC_CTRL_RESET);
    wr(OSC_CTRL_ADDR, 8'h74);
    rd_chk(8'h04);
    check({7'h00, sub_osc_en}, 8'h00);
    wr(OSC_CTRL_ADDR, 8'h00);
    wr(8'hf9, 8'hff);
    rd_chk(8'h00);
    wr(OSC_CTRL_ADDR, 8'h81);
    rd_chk(8'h81);
    check({7'h00, sub_pwr_save}, 8'h01);
    wait_src(1'b1);
    wr(OSC_CTRL_ADDR, 8'h89);
    repeat (3) @(posedge ref_clk);
    #1;
    check({6'h00, main_osc_en, sub_osc_en}, 8'h01);
    rd_chk(8'h89);
    wr(OSC_CTRL_ADDR, 8'h80);
    repeat (3) @(posedge ref_clk);
    #1;
    check({5'h00, switch_busy, main_osc_en, sys_clk_is_sub}, 8'h07);
    wait_src(1'b0);
    wr(OSC_CTRL_ADDR, 8'h81);
    wait_src(1'b1);
    @(posedge ref_clk);
    stop_mode <= 1'b1;
    @(posedge ref_clk);
    stop_mode <= 1'b0;
    rd_chk(8'h01);
    check({6'h00, switch_busy, sub_pwr_save}, 8'h00);
    // stop mode on main keeps bit 7
    wr(OSC_CTRL_ADDR, 8'h80);
    wait_src(1'b0);
    @(posedge ref_clk);
    stop_mode <= 1'b1;
    @(posedge ref_clk);
    stop_mode <= 1'b0;
    rd_chk(8'h80);
    check({7'h00, sub_pwr_save}, 8'h01);
    wr(OSC_CTRL_ADDR, 8'h84);
    rd_chk(8'h04);
    check({7'h00, sub_pwr_save}, 8'h00);
    wr(OSC_CTRL_ADDR, 8'h84);
    rd_chk(8'h04);
    summarize();
  end
endmodule : oscillator_clock_select_tb_top
